// *** qdu_consts.svh ***
// Constants for the quad converter update slave
`ifndef QDU_CONSTS_SVH
`define QDU_CONSTS_SVH

// Clock and bus rates, in hertz and bits per second
`define QDU_CLK_HZ        40000000
`define QDU_STD_BPS       100000
`define QDU_FAST_BPS      400000
`define QDU_HS_BPS        3400000
// Shortest high-speed bit period in clk cycles, rounded down
`define QDU_HS_BIT_CYC    (`QDU_CLK_HZ / `QDU_HS_BPS)

// Cycles after reset release before the select pins are captured
`define QDU_STRAP_CYC     2'h3

// Address byte layout
`define QDU_ADDR_PREFIX   5'h13
`define QDU_BCAST_ADDR    8'h90
`define QDU_HS_CODE       5'h01
`define QDU_BITS_PER_BYTE 4'h8

// Control byte field positions
`define QDU_CB_EXT_HI     7
`define QDU_CB_EXT_LO     6
`define QDU_CB_LOAD_HI    5
`define QDU_CB_LOAD_LO    4
`define QDU_CB_PICK_HI    2
`define QDU_CB_PICK_LO    1
`define QDU_CB_PD         0

// Load mode encodings
`define QDU_LOAD_TEMP     2'h0
`define QDU_LOAD_ONE      2'h1
`define QDU_LOAD_SYNC     2'h2
`define QDU_LOAD_BCAST    2'h3

// Reset values
`define QDU_CTRL_RST      8'h00
`define QDU_CHAN_RST      17'h00000

`endif

// *** qdu_pkg.sv ***
// Types for the quad converter update slave
package qdu_pkg;

  typedef enum logic [3:0] {
    QDU_ST_IDLE = 4'h1,
    QDU_ST_RECV = 4'h2,
    QDU_ST_ACK  = 4'h4,
    QDU_ST_SKIP = 4'h8
  } qdu_state_type;

  typedef enum logic [1:0] {
    QDU_PH_ADDR = 2'h0,
    QDU_PH_CTRL = 2'h1,
    QDU_PH_MSB  = 2'h2,
    QDU_PH_LSB  = 2'h3
  } qdu_phase_type;

  // Power-down flag above a 16-bit code
  typedef logic [16:0] qdu_chan_type;
  typedef logic [3:0]  qdu_mask_type;

endpackage : qdu_pkg

// *** qdu_pin_sync.sv ***
// Two-stage synchroniser with a delayed copy for edge finding
`timescale 1ns/100ps
module qdu_pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] sync_prev
);

  logic [WIDTH-1:0] meta;

  // Lines idle high, so reset to ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta      <= '1;
      sync_out  <= '1;
      sync_prev <= '1;
    end else begin
      meta      <= async_in;
      sync_out  <= meta;
      sync_prev <= sync_out;
    end
  end

endmodule : qdu_pin_sync

// *** qdu_update_slave.sv ***
// Two-wire slave front end of a quad 16-bit converter with channel update logic
// Summary of operation
// - Standard, fast and high-speed rates, one protocol
// - Only 7-bit addresses; never acknowledge others
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Acknowledge own address through ninth clock high
// - Bytes of eight bits plus acknowledge repeat
// - Master code enters high speed, not acknowledged
// - High speed until stop returns standard/fast
// - Start, address, control, upper, lower bytes
// - Acknowledge every received write byte
// - Update at falling edge of lower acknowledge
// - Control kept; further byte pairs update again
// - Stop releases bus, returns to idle
// - Address is 10011, select pins, direction
// - Select pins captured once after power-up
// - Broadcast address 0x90 ignores select pins
// - Broadcast accepted for writes only
// - Control: ext, load, spare, pick, power-down
// - Extended bits must match pins, except in broadcast load mode
// - Load modes: temp, one, sync-all, broadcast
// - Broadcast mode: pick high selects new data
`timescale 1ns/100ps
`include "qdu_consts.svh"
module qdu_update_slave (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  input  wire logic           dev_pin_hi,
  input  wire logic           dev_pin_lo,
  input  wire logic           ext_addr_hi,
  input  wire logic           ext_addr_lo,
  output logic                sda_out,
  output logic                sda_oe,
  output logic                high_speed_mode,
  output logic                update_strobe,
  output logic         [63:0] dac_codes,
  output qdu_pkg::qdu_mask_type dac_power_down
);
  import qdu_pkg::*;

  logic [5:0]    pin_now;
  logic [5:0]    pin_prev;
  logic [1:0]    strap_cnt;
  logic [1:0]    dev_sel;
  qdu_state_type state;
  qdu_state_type next_state;
  qdu_phase_type phase;
  logic [3:0]    bit_cnt;
  logic [7:0]    shreg;
  logic          read_flag;
  logic          upd_pend;
  logic [7:0]    mode_control_byte;
  logic [7:0]    data_hi;
  logic [15:0]   data_word;
  qdu_chan_type  temp_reg [4];
  qdu_chan_type  out_reg  [4];

  qdu_pin_sync #(.WIDTH(6)) u_sync (
    .clk       (clk),
    .nrst      (nrst),
    .async_in  ({scl_in, sda_in, dev_pin_hi, dev_pin_lo, ext_addr_hi, ext_addr_lo}),
    .sync_out  (pin_now),
    .sync_prev (pin_prev)
  );

  // Bus events seen on the synchronised lines
  wire scl_s      = pin_now[5];
  wire scl_p      = pin_prev[5];
  wire sda_s      = pin_now[4];
  wire sda_p      = pin_prev[4];
  wire scl_rise   = scl_s & ~scl_p;
  wire scl_fall   = ~scl_s & scl_p;
  wire strap_done = (strap_cnt == `QDU_STRAP_CYC);
  wire start_cond = strap_done & scl_s & scl_p & sda_p & ~sda_s;
  wire stop_cond  = strap_done & scl_s & scl_p & ~sda_p & sda_s;
  wire [1:0] ext_pins = pin_now[1:0];

  // Address decode at the end of each byte
  wire byte_done  = (state == QDU_ST_RECV) & scl_fall & (bit_cnt == `QDU_BITS_PER_BYTE);
  wire addr_own   = (shreg[7:1] == {`QDU_ADDR_PREFIX, dev_sel});
  wire addr_bcast = (shreg == `QDU_BCAST_ADDR);
  wire addr_hs    = (shreg[7:3] == `QDU_HS_CODE);
  wire in_addr    = (phase == QDU_PH_ADDR);
  // Only 7-bit own or broadcast-write addresses are taken
  wire accept     = in_addr ? (addr_own | addr_bcast) : 1'b1;

  // Control byte fields
  wire [1:0] load_mode = {mode_control_byte[`QDU_CB_LOAD_HI], mode_control_byte[`QDU_CB_LOAD_LO]};
  wire [1:0] pick      = {mode_control_byte[`QDU_CB_PICK_HI], mode_control_byte[`QDU_CB_PICK_LO]};
  wire [1:0] ext_bits  = {mode_control_byte[`QDU_CB_EXT_HI], mode_control_byte[`QDU_CB_EXT_LO]};
  wire       is_bcast  = (load_mode == `QDU_LOAD_BCAST);
  wire       ext_ok    = is_bcast | (ext_bits == ext_pins);
  wire       ack_end   = (state == QDU_ST_ACK) & scl_fall;
  wire       do_update = ack_end & upd_pend & ext_ok;
  wire qdu_chan_type new_entry = {mode_control_byte[`QDU_CB_PD], data_word};

  // Whether channel ch takes the new data into its temporary register
  function automatic logic temp_load(input logic [1:0] mode, input logic [1:0] sel,
                                     input logic [1:0] ch);
    temp_load = (mode == `QDU_LOAD_BCAST) ? sel[1] : (sel == ch);
  endfunction : temp_load

  // Output register source: 2 new data, 1 temporary copy, 0 hold
  function automatic logic [1:0] out_src(input logic [1:0] mode, input logic [1:0] sel,
                                         input logic [1:0] ch);
    case (mode)
      `QDU_LOAD_ONE:   out_src = (sel == ch) ? 2'h2 : 2'h0;
      `QDU_LOAD_SYNC:  out_src = (sel == ch) ? 2'h2 : 2'h1;
      `QDU_LOAD_BCAST: out_src = sel[1] ? 2'h2 : 2'h1;
      default:         out_src = 2'h0;
    endcase
  endfunction : out_src

  // Capture the device-select pins once after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt <= 2'h0;
      dev_sel   <= 2'h0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `QDU_STRAP_CYC - 2'h1) begin
        dev_sel <= pin_now[3:2];
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      QDU_ST_IDLE: next_state = QDU_ST_IDLE;
      QDU_ST_RECV: begin
        if (byte_done) begin
          next_state = accept ? QDU_ST_ACK : QDU_ST_SKIP;
        end
      end
      QDU_ST_ACK: begin
        if (scl_fall) begin
          next_state = read_flag ? QDU_ST_SKIP : QDU_ST_RECV;
        end
      end
      QDU_ST_SKIP: next_state = QDU_ST_SKIP;
      default:     next_state = QDU_ST_IDLE;
    endcase
    if (start_cond) begin
      next_state = QDU_ST_RECV;
    end else if (stop_cond) begin
      next_state = QDU_ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= QDU_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit shifting and byte phase tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      phase     <= QDU_PH_ADDR;
      read_flag <= 1'b0;
    end else if (start_cond) begin
      bit_cnt   <= 4'h0;
      phase     <= QDU_PH_ADDR;
      read_flag <= 1'b0;
    end else if (state == QDU_ST_RECV && scl_rise && bit_cnt != `QDU_BITS_PER_BYTE) begin
      shreg   <= {shreg[6:0], sda_s};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (byte_done) begin
      case (phase)
        QDU_PH_ADDR: begin
          phase     <= QDU_PH_CTRL;
          read_flag <= shreg[0];
        end
        QDU_PH_CTRL: phase <= QDU_PH_MSB;
        QDU_PH_MSB:  phase <= QDU_PH_LSB;
        QDU_PH_LSB:  phase <= QDU_PH_MSB;
        default:     phase <= QDU_PH_ADDR;
      endcase
    end else if (ack_end) begin
      bit_cnt <= 4'h0;
    end
  end

  // Control byte and data word assembly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_control_byte <= `QDU_CTRL_RST;
      data_hi           <= 8'h00;
      data_word         <= 16'h0000;
      upd_pend          <= 1'b0;
    end else if (start_cond || stop_cond) begin
      upd_pend <= 1'b0;
    end else if (byte_done) begin
      case (phase)
        QDU_PH_CTRL: mode_control_byte <= shreg;
        QDU_PH_MSB:  data_hi <= shreg;
        QDU_PH_LSB: begin
          data_word <= {data_hi, shreg};
          upd_pend  <= 1'b1;
        end
        default:     upd_pend <= 1'b0;
      endcase
    end else if (ack_end) begin
      upd_pend <= 1'b0;
    end
  end

  // Acknowledge drive and mode flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_out         <= 1'b0;
      sda_oe          <= 1'b0;
      high_speed_mode <= 1'b0;
      update_strobe   <= 1'b0;
    end else begin
      sda_out       <= 1'b0;
      update_strobe <= do_update;
      if (start_cond || stop_cond || ack_end) begin
        sda_oe <= 1'b0;
      end else if (byte_done && accept) begin
        sda_oe <= 1'b1;
      end
      if (stop_cond) begin
        high_speed_mode <= 1'b0;
      end else if (byte_done && in_addr && addr_hs) begin
        high_speed_mode <= 1'b1;
      end
    end
  end

  // Per-channel temporary and output registers
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    wire       t_ld = temp_load(load_mode, pick, 2'(ch));
    wire [1:0] o_sr = out_src(load_mode, pick, 2'(ch));

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        temp_reg[ch] <= `QDU_CHAN_RST;
        out_reg[ch]  <= `QDU_CHAN_RST;
      end else if (do_update) begin
        if (t_ld) begin
          temp_reg[ch] <= new_entry;
        end
        if (o_sr == 2'h2) begin
          out_reg[ch] <= new_entry;
        end else if (o_sr == 2'h1) begin
          out_reg[ch] <= temp_reg[ch];
        end
      end
    end

    assign dac_codes[16*ch +: 16] = out_reg[ch][15:0];
    assign dac_power_down[ch]     = out_reg[ch][16];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ack_own_addr: assert property (
    byte_done && in_addr && addr_own |=> sda_oe ##1 sda_oe[*1])
    else $error("own address not acknowledged");

  a_no_foreign_ack: assert property (
    byte_done && in_addr && !addr_own && !addr_bcast |=> !sda_oe && state == QDU_ST_SKIP)
    else $error("foreign address acknowledged");

  a_bcast_read_nak: assert property (
    byte_done && in_addr && shreg == (`QDU_BCAST_ADDR | 8'h01) && !addr_own |=> !sda_oe)
    else $error("broadcast read acknowledged");

  a_hs_entry: assert property (
    byte_done && in_addr && addr_hs |=> high_speed_mode && !sda_oe)
    else $error("master code handled wrongly");

  a_stop_idle: assert property (
    stop_cond |=> state == QDU_ST_IDLE && !sda_oe && !high_speed_mode)
    else $error("stop did not release bus");

  a_start_addr: assert property (
    start_cond |=> state == QDU_ST_RECV && phase == QDU_PH_ADDR && bit_cnt == 4'h0)
    else $error("start did not restart address phase");

  a_ack_holds: assert property (
    sda_oe && !scl_fall && !start_cond && !stop_cond |=> sda_oe)
    else $error("acknowledge dropped early");

  a_update_moment: assert property (
    ack_end && upd_pend && ext_ok |=> update_strobe ##1 !update_strobe)
    else $error("update not at acknowledge fall");

  a_ext_block: assert property (
    ack_end && upd_pend && !is_bcast && ext_bits != ext_pins |=> !update_strobe)
    else $error("update despite extended address mismatch");

  a_code_join: assert property (
    update_strobe && load_mode == `QDU_LOAD_ONE |-> dac_codes[16*pick +: 16] == data_word)
    else $error("code not loaded into selected channel");

  c_own_update:  cover property (update_strobe && load_mode == `QDU_LOAD_ONE);
  c_sync_update: cover property (update_strobe && load_mode == `QDU_LOAD_SYNC);
  c_bcast_new:   cover property (update_strobe && is_bcast && pick[1]);
  c_hs_entered:  cover property ($rose(high_speed_mode));

endmodule : qdu_update_slave

// *** qdu_bus_master.sv ***
// Two-wire bus master model that drives the link of the update slave
`timescale 1ns/100ps
module qdu_bus_master (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);

  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Every change lands just after a clk edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Acts as a repeated start when entered with the clock low
  task automatic start_cond();
    step(2);
    sda_low = 1'b0;
    step(2);
    scl = 1'b1;
    step(4);
    sda_low = 1'b1;
    step(4);
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    step(2);
    sda_low = 1'b1;
    step(2);
    scl = 1'b1;
    step(4);
    sda_low = 1'b0;
    step(4);
  endtask : stop_cond

  // Data moves mid-way through the low phase; the wire is read twice while high
  task automatic put_bit(input logic b, output logic seen);
    step(2);
    sda_low = !b;
    step(2);
    scl = 1'b1;
    step(1);
    seen = sda_wire;
    step(2);
    seen = seen | sda_wire;
    step(1);
    scl = 1'b0;
  endtask : put_bit

  // Eight bits MSB first, then the wire is released for the answer
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    acked = !s;
  endtask : send_byte

endmodule : qdu_bus_master

// *** tb.sv ***
// Self-checking bench for the update slave
`timescale 1ns/100ps
module tb;
  import qdu_pkg::*;

  localparam int LIMIT = 30000;

  logic         clk        = 1'b0;
  logic         nrst       = 1'b0;
  logic         dev_pin_hi = 1'b1;
  logic         dev_pin_lo = 1'b0;
  logic         ext_addr_hi = 1'b0;
  logic         ext_addr_lo = 1'b1;
  logic         sda_out;
  logic         sda_oe;
  logic         high_speed_mode;
  logic         update_strobe;
  logic         scl;
  logic         sda_low;
  logic         ack;
  logic [63:0]  dac_codes;
  qdu_mask_type dac_power_down;
  wire          sda_wire = !(sda_low || (sda_oe && !sda_out));
  int           mismatches = 0;
  int           n_compared = 0;
  int           n_upd      = 0;
  int           cycles     = 0;
  int           n_old;

  qdu_update_slave u_qdu_update_slave (
    .clk,
    .nrst,
    .scl_in          (scl),
    .sda_in          (sda_wire),
    .dev_pin_hi,
    .dev_pin_lo,
    .ext_addr_hi,
    .ext_addr_lo,
    .sda_out,
    .sda_oe,
    .high_speed_mode,
    .update_strobe,
    .dac_codes,
    .dac_power_down
  );

  qdu_bus_master u_qdu_bus_master (
    .clk,
    .sda_wire,
    .scl,
    .sda_low
  );

  always #12.5 clk = !clk;

  // Counts update pulses and cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (update_strobe === 1'b1) begin
      n_upd++;
    end
    if (cycles == LIMIT) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Start (or repeated start), then bytes, each answered as expected
  task automatic xfer(input logic [7:0] b[$], input logic exp_ack);
    u_qdu_bus_master.start_cond();
    foreach (b[i]) begin
      u_qdu_bus_master.send_byte(b[i], ack);
      chk("ack", {63'h0, exp_ack}, {63'h0, ack});
    end
  endtask : xfer

  task automatic wr(input logic [7:0] b[$]);
    xfer(b, 1'b1);
    u_qdu_bus_master.stop_cond();
  endtask : wr

  task automatic chk_out(input logic [63:0] codes, input logic [3:0] pd);
    chk("codes", codes, dac_codes);
    chk("power_down", {60'h0, pd}, {60'h0, dac_power_down});
    chk("sda_oe", 64'h0, {63'h0, sda_oe});
  endtask : chk_out

  initial begin
    logic [7:0] refused[4];
    refused = '{8'h98, 8'h00, 8'hf0, 8'h91};
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk_out(64'h0, 4'h0);
    chk("hs", 64'h0, {63'h0, high_speed_mode});
    // Select pins move after capture; the captured address stays
    dev_pin_hi = 1'b0;
    foreach (refused[i]) begin
      xfer('{refused[i]}, 1'b0);
      u_qdu_bus_master.stop_cond();
    end
    wr('{8'h9c, 8'h52, 8'h12, 8'h34, 8'hab, 8'hcd});
    chk_out(64'h0000_0000_abcd_0000, 4'h0);
    chk("updates", 64'd2, 64'(n_upd));
    wr('{8'h9c, 8'h44, 8'h55, 8'h55});
    wr('{8'h9c, 8'h46, 8'h77, 8'h77});
    chk_out(64'h0000_0000_abcd_0000, 4'h0);
    wr('{8'h9c, 8'h60, 8'h11, 8'h11});
    chk_out(64'h7777_5555_abcd_1111, 4'h0);
    n_old = n_upd;
    wr('{8'h9c, 8'h90, 8'h22, 8'h22});
    chk_out(64'h7777_5555_abcd_1111, 4'h0);
    chk("updates", 64'(n_old), 64'(n_upd));
    wr('{8'h9c, 8'h40, 8'h33, 8'h33});
    wr('{8'h90, 8'h30, 8'h00, 8'h00});
    chk_out(64'h7777_5555_abcd_3333, 4'h0);
    wr('{8'h90, 8'h35, 8'h0f, 8'h0f});
    chk_out(64'h0f0f_0f0f_0f0f_0f0f, 4'hf);
    // Master code, repeated start, high-speed update, then stop
    xfer('{8'h09}, 1'b0);
    chk("hs", 64'h1, {63'h0, high_speed_mode});
    xfer('{8'h9c, 8'h52, 8'h00, 8'h01}, 1'b1);
    chk("hs", 64'h1, {63'h0, high_speed_mode});
    u_qdu_bus_master.stop_cond();
    chk("hs", 64'h0, {63'h0, high_speed_mode});
    chk_out(64'h0f0f_0f0f_0001_0f0f, 4'hd);
    // A half pair cut off by a stop must not update
    n_old = n_upd;
    wr('{8'h9c, 8'h52, 8'h99});
    chk_out(64'h0f0f_0f0f_0001_0f0f, 4'hd);
    chk("updates", 64'(n_old), 64'(n_upd));
    // Own address with read is acknowledged, then the bus is left alone
    xfer('{8'h9d}, 1'b1);
    u_qdu_bus_master.send_byte(8'hff, ack);
    chk("read_release", 64'h0, {63'h0, ack});
    u_qdu_bus_master.stop_cond();
    chk_out(64'h0f0f_0f0f_0001_0f0f, 4'hd);
    chk("updates", 64'(n_old), 64'(n_upd));
    conclude();
  end

endmodule : tb
